// [design/sehc_pkg.sv]
// Package of constants and carrier types for the serial memory pause control block.
package sehc_pkg;

  // ****************************************
  // Timing and widths
  // ****************************************
  localparam int unsigned SEHC_CLK_HZ = 25000000;
  // Power-on guard time in ns, counted after the synchronous reset is released.
  localparam int unsigned SEHC_POR_NS = 1000;
  localparam int unsigned SEHC_POR_CYC = (SEHC_POR_NS * (SEHC_CLK_HZ / 1000000) + 999) / 1000;
  localparam int unsigned SEHC_POR_W = 6;
  localparam logic [SEHC_POR_W-1:0] SEHC_POR_LAST = SEHC_POR_CYC[SEHC_POR_W-1:0] - 6'h01;
  localparam logic [2:0] SEHC_BIT_RST = 3'h0;
  localparam logic [7:0] SEHC_BYTE_RST = 8'h00;
  localparam logic [7:0] SEHC_SHIFT_RST = 8'h00;

  // ****************************************
  // Types
  // ****************************************
  // Pin levels, before and after synchronisation.
  typedef struct packed {
    logic sclk;
    logic sel_n;
    logic pause_n;
    logic sdi;
  } sehc_pins_t;

  // Serial position kept across a pause.
  typedef struct packed {
    logic [2:0] bit_cnt;
    logic [7:0] byte_cnt;
    logic [7:0] shift;
  } sehc_pos_t;

  // Interface state machine, Gray coded along the usual path.
  typedef enum logic [1:0] {
    SEHC_ST_POR = 2'b00,
    SEHC_ST_IDLE = 2'b01,
    SEHC_ST_ACTIVE = 2'b11,
    SEHC_ST_PAUSED = 2'b10
  } sehc_state_t;

endpackage : sehc_pkg

// [design/sehc_sync.sv]
// Two flip-flop synchroniser for the serial interface pins.
`timescale 1ns/10ps
`default_nettype none
module sehc_sync
  import sehc_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire sehc_pins_t pins_async,
  output sehc_pins_t pins_sync
);

  sehc_pins_t meta_reg;
  sehc_pins_t sync_reg;

  // Idle pin levels are deselected, not paused, clock low.
  localparam sehc_pins_t SEHC_PINS_IDLE = '{sclk: 1'b0, sel_n: 1'b1, pause_n: 1'b1, sdi: 1'b0};

  // First stage feeds only the second stage.
  always_ff @(posedge clk) begin
    if (srst) begin
      meta_reg <= SEHC_PINS_IDLE;
      sync_reg <= SEHC_PINS_IDLE;
    end else begin
      meta_reg <= pins_async;
      sync_reg <= meta_reg;
    end
  end

  assign pins_sync = sync_reg;

endmodule : sehc_sync
`default_nettype wire

// [design/sehc_top.sv]
// Pause control of the serial interface of a small serial memory, device side.
`timescale 1ns/10ps
`default_nettype none
module sehc_top
  import sehc_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic sclk,
  input wire logic sel_n,
  input wire logic pause_n,
  input wire logic sdi,
  input wire logic sdo_data,
  input wire logic sdo_req,
  input wire logic write_busy,
  output logic sdo_o,
  output logic sdo_oe,
  output logic bit_strobe,
  output logic [7:0] rx_byte,
  output logic byte_strobe,
  output logic [7:0] byte_count,
  output logic paused,
  output logic if_ready,
  output logic abort_pulse
);

  // ****************************************
  // Pin synchronisation
  // ****************************************
  sehc_pins_t pins_async;
  sehc_pins_t pins;

  assign pins_async = '{sclk: sclk, sel_n: sel_n, pause_n: pause_n, sdi: sdi};

  sehc_sync u_sync (
    .clk(clk),
    .srst(srst),
    .pins_async(pins_async),
    .pins_sync(pins)
  );

  // ****************************************
  // Edge detection and decode
  // ****************************************
  logic sclk_d_reg;
  logic sel_n_d_reg;
  sehc_state_t state_reg;
  sehc_state_t state_next;
  sehc_pos_t pos_reg;
  sehc_pos_t pos_next;
  logic [SEHC_POR_W-1:0] por_cnt_reg;
  logic sdo_o_reg;
  logic sdo_oe_reg;
  logic bit_strobe_reg;
  logic byte_strobe_reg;
  logic [7:0] rx_byte_reg;
  logic abort_reg;
  logic paused_reg;

  // Previous samples used to find edges of the serial clock and the select line.
  always_ff @(posedge clk) begin
    if (srst) begin
      sclk_d_reg <= 1'b0;
      sel_n_d_reg <= 1'b1;
    end else begin
      sclk_d_reg <= pins.sclk;
      sel_n_d_reg <= pins.sel_n;
    end
  end

  wire sclk_rise = pins.sclk & ~sclk_d_reg;
  wire sclk_fall = ~pins.sclk & sclk_d_reg;
  wire selected = ~pins.sel_n;
  // A pause change is honoured only with the clock low, or at a falling edge.
  wire clk_low_now = ~pins.sclk;
  wire want_pause = ~pins.pause_n & clk_low_now;
  wire want_resume = pins.pause_n & clk_low_now;
  wire por_done = (por_cnt_reg == SEHC_POR_LAST);
  wire shift_in = (state_reg == SEHC_ST_ACTIVE) & sclk_rise & ~want_pause;
  wire shift_out = (state_reg == SEHC_ST_ACTIVE) & sclk_fall & ~want_pause;
  wire byte_done = shift_in & (pos_reg.bit_cnt == 3'h7);

  // ****************************************
  // Power-on guard
  // ****************************************
  // Counts out the guard time; select activity before it ends is ignored.
  always_ff @(posedge clk) begin
    if (srst) begin
      por_cnt_reg <= '0;
    end else if (!por_done) begin
      por_cnt_reg <= por_cnt_reg + 6'h01;
    end
  end

  // ****************************************
  // Interface state machine
  // ****************************************
  // Next state: selection opens a frame, pause freezes it, deselect closes it.
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      SEHC_ST_POR: begin
        // Leave the guard only with the device deselected, so no glitch starts a frame.
        if (por_done && pins.sel_n) begin
          state_next = SEHC_ST_IDLE;
        end
      end
      SEHC_ST_IDLE: begin
        // Only a fresh select falling edge opens a frame; pause is ignored here.
        if (selected && sel_n_d_reg) begin
          state_next = SEHC_ST_ACTIVE;
        end
      end
      SEHC_ST_ACTIVE: begin
        if (!selected) begin
          state_next = SEHC_ST_IDLE;
        end else if (want_pause) begin
          state_next = SEHC_ST_PAUSED;
        end
      end
      SEHC_ST_PAUSED: begin
        if (!selected) begin
          state_next = SEHC_ST_IDLE;
        end else if (want_resume) begin
          state_next = SEHC_ST_ACTIVE;
        end
      end
      default: begin
        state_next = SEHC_ST_POR;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_reg <= SEHC_ST_POR;
    end else begin
      state_reg <= state_next;
    end
  end

  // ****************************************
  // Serial position
  // ****************************************
  // Position advances only on clock edges while active; a pause holds it.
  always_comb begin
    pos_next = pos_reg;
    if (state_next == SEHC_ST_IDLE || state_next == SEHC_ST_POR) begin
      pos_next = '{bit_cnt: SEHC_BIT_RST, byte_cnt: SEHC_BYTE_RST, shift: SEHC_SHIFT_RST};
    end else if (shift_in) begin
      pos_next.shift = {pos_reg.shift[6:0], pins.sdi};
      pos_next.bit_cnt = pos_reg.bit_cnt + 3'h1;
      if (pos_reg.bit_cnt == 3'h7) begin
        pos_next.byte_cnt = pos_reg.byte_cnt + 8'h01;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      pos_reg <= '{bit_cnt: SEHC_BIT_RST, byte_cnt: SEHC_BYTE_RST, shift: SEHC_SHIFT_RST};
    end else begin
      pos_reg <= pos_next;
    end
  end

  // ****************************************
  // Output stage and status
  // ****************************************
  // Serial output changes on falling clock edges and on entry to the active state, and is released during a pause.
  // The write engine's busy flag is only observed, never driven, from here.
  always_ff @(posedge clk) begin
    if (srst) begin
      sdo_o_reg <= 1'b0;
      sdo_oe_reg <= 1'b0;
      bit_strobe_reg <= 1'b0;
      byte_strobe_reg <= 1'b0;
      rx_byte_reg <= 8'h00;
      abort_reg <= 1'b0;
      paused_reg <= 1'b0;
    end else begin
      if (state_next != SEHC_ST_ACTIVE) begin
        sdo_oe_reg <= 1'b0;
      end else if (shift_out || state_reg != SEHC_ST_ACTIVE) begin
        sdo_o_reg <= sdo_data;
        sdo_oe_reg <= sdo_req;
      end
      bit_strobe_reg <= shift_in;
      byte_strobe_reg <= byte_done;
      if (byte_done) begin
        rx_byte_reg <= {pos_reg.shift[6:0], pins.sdi};
      end
      // Abort flags a frame deselected while paused; none is flagged while the write engine is busy.
      abort_reg <= (state_reg == SEHC_ST_PAUSED) & ~selected & ~write_busy;
      paused_reg <= (state_next == SEHC_ST_PAUSED);
    end
  end

  assign sdo_o = sdo_o_reg;
  assign sdo_oe = sdo_oe_reg;
  assign bit_strobe = bit_strobe_reg;
  assign byte_strobe = byte_strobe_reg;
  assign rx_byte = rx_byte_reg;
  assign byte_count = pos_reg.byte_cnt;
  assign paused = paused_reg;
  assign if_ready = state_reg[0];
  assign abort_pulse = abort_reg;

endmodule : sehc_top
`default_nettype wire

// [dv/sehc_checker.sv]
// Assertion checker on the ports of the pause control block.
`timescale 1ns/10ps
`default_nettype none
module sehc_checker (
  input wire logic clk,
  input wire logic srst,
  input wire logic sclk,
  input wire logic sel_n,
  input wire logic pause_n,
  input wire logic sdo_oe,
  input wire logic bit_strobe,
  input wire logic byte_strobe,
  input wire logic [7:0] rx_byte,
  input wire logic [7:0] byte_count,
  input wire logic paused,
  input wire logic if_ready,
  input wire logic abort_pulse
);
  // ****
  // Properties
  // ****
  // All checks use the block clock and stop during reset unless noted.
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  AST_PAUSE_OE:
    assert property (paused |-> !sdo_oe) else $error("output driven while paused");
  AST_PAUSE_NOBIT:
    assert property (paused |-> !bit_strobe && !byte_strobe) else $error("bit taken while paused");
  AST_PAUSE_KEEP:
    assert property (paused ##1 paused |-> $stable(byte_count) && $stable(rx_byte)) else $error("position lost");
  AST_SEL_NOPAUSE:
    assert property (sel_n [*6] |-> !paused) else $error("paused while deselected");
  AST_ABORT:
    assert property (abort_pulse |=> !abort_pulse && !paused) else $error("abort pulse wrong");
  AST_ENTER:
    assert property (!sclk && !sel_n && if_ready && $fell(pause_n) |-> ##[1:8] paused) else $error("no pause");
  AST_EXIT:
    assert property (paused && !sclk && !sel_n && $rose(pause_n) |-> ##[1:8] !paused) else $error("no resume");
  AST_RESET:
    assert property (disable iff (1'h0) srst |=> !paused && !if_ready && !sdo_oe) else $error("reset state");
  AST_POR:
    assert property (disable iff (1'h0) $fell(srst) |-> !if_ready [*8]) else $error("guard too short");
  AST_PAUSE_LOW:
    assert property ($rose(paused) |-> !$past(sclk, 3) && !$past(pause_n, 3))
      else $error("pause began with clock high");
  AST_RESUME_LOW:
    assert property ($fell(paused) && !$past(sel_n, 3) |-> !$past(sclk, 3) && $past(pause_n, 3))
      else $error("pause ended with clock high");
  // Main scenarios reached.
  cover property (paused);
  cover property (abort_pulse);
  cover property (byte_strobe);
endmodule : sehc_checker
`default_nettype wire

// [dv/sehc_master.sv]
// Serial bus master model driving clock, select, pause and data.
`timescale 1ns/10ps
`default_nettype none
module sehc_master (
  input wire logic clk,
  output logic sclk = 1'h0,
  output logic sel_n = 1'h1,
  output logic pause_n = 1'h1,
  output logic sdi = 1'h0
);
  // ****
  // Pin driving
  // ****
  // The data line keeps changing while deselected.
  always @(posedge clk) begin
    if (sel_n) begin
      sdi <= ~sdi;
    end
  end
  // Changes select, then lets the pins settle.
  task automatic sel(input logic v);
    @(posedge clk);
    sel_n <= v;
    repeat (4) @(posedge clk);
  endtask : sel
  // Pulls the pause line low for n cycles.
  task automatic hold(input int n);
    @(posedge clk);
    pause_n <= 1'h0;
    repeat (n) @(posedge clk);
    pause_n <= 1'h1;
  endtask : hold
  // Sends a byte MSB first, pausing before bit h; sclk is wiggled and data inverted in the pause.
  task automatic xfer(input logic [7:0] b, input int h, input logic ab);
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      sdi <= (i == h) ? ~b[7-i] : b[7-i];
      if (i == h) begin
        pause_n <= 1'h0;
        repeat (6) @(posedge clk);
        sclk <= 1'h1;
        repeat (2) @(posedge clk);
        // Odd positions, unless aborting, release the pause with the clock high; it may end only at the clock fall.
        if (h[0] && !ab) begin
          pause_n <= 1'h1;
        end
        repeat (2) @(posedge clk);
        sclk <= 1'h0;
        repeat (6) @(posedge clk);
        if (ab) begin
          sel_n <= 1'h1;
          repeat (6) @(posedge clk);
          pause_n <= 1'h1;
          return;
        end
        pause_n <= 1'h1;
        sdi <= b[7-i];
      end
      repeat (4) @(posedge clk);
      sclk <= 1'h1;
      repeat (4) @(posedge clk);
      sclk <= 1'h0;
    end
  endtask : xfer
endmodule : sehc_master
`default_nettype wire

// [dv/sehc_top_tb.sv]
// Self-checking testbench of the pause control block.
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin n_errors++; $display("BAD %0t mismatch", $time); end end
module sehc_top_tb;
  import sehc_pkg::*;
  logic clk = 1'h0, srst = 1'h1, sdo_data = 1'h0, sdo_req = 1'h0, write_busy = 1'h0;
  logic sclk, sel_n, pause_n, sdi, sdo_o, sdo_oe, bit_strobe, byte_strobe, paused, if_ready, abort_pulse;
  logic [7:0] rx_byte, byte_count, b;
  logic exp_sdo = 1'h0, exp_oe = 1'h0;
  logic [2:0] sh = 3'h0;
  int n_errors = 0, compares = 0, nbits = 0, naborts = 0, npause = 0, cyc = 0, k0, a0;
  int seed = 32'hd5bf_bdfa;
  // ****
  // Harness
  // ****
  // Clock of 40 ns.
  always #20 clk = ~clk;
  sehc_top i_sehc_top (.clk(clk), .srst(srst), .sclk(sclk), .sel_n(sel_n), .pause_n(pause_n), .sdi(sdi),
    .sdo_data(sdo_data), .sdo_req(sdo_req), .write_busy(write_busy), .sdo_o(sdo_o), .sdo_oe(sdo_oe),
    .bit_strobe(bit_strobe), .rx_byte(rx_byte), .byte_strobe(byte_strobe), .byte_count(byte_count),
    .paused(paused), .if_ready(if_ready), .abort_pulse(abort_pulse));
  sehc_master i_sehc_master (.clk(clk), .sclk(sclk), .sel_n(sel_n), .pause_n(pause_n), .sdi(sdi));
  // Drives random core inputs, counts pulses and cuts a hang short.
  always @(posedge clk) begin
    cyc++;
    sdo_data <= 1'($random(seed));
    sdo_req <= 1'($random(seed));
    // The core's output bit is taken three cycles after a clock fall on the pin.
    sh <= {sh[1:0], sclk};
    if (sh[2] && !sh[1]) begin
      exp_sdo <= sdo_data;
      exp_oe <= sdo_req;
    end
    nbits += (bit_strobe === 1'h1);
    naborts += (abort_pulse === 1'h1);
    npause += (paused === 1'h1);
    if (cyc == 20000) begin
      n_errors++;
      print_verdict();
    end
  end
  // Expected number of bit strobes for whole bytes.
  function automatic int exp_bits(input int nbytes);
    return nbytes * 8;
  endfunction : exp_bits
  // Prints the counts and the verdict, then ends the run.
  task automatic print_verdict();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : print_verdict
  // One frame of one byte, paused before bit h; if deselected in the pause, an unpaused frame with the same byte follows.
  task automatic frame(input int h, input logic ab, input logic wb);
    @(posedge clk);
    write_busy <= wb;
    b = 8'($random(seed));
    k0 = nbits;
    a0 = naborts;
    npause = 0;
    i_sehc_master.sel(1'h0);
    i_sehc_master.xfer(b, h, ab);
    repeat (8) @(posedge clk);
    if (ab) begin
      `CHK(naborts - a0, wb ? 0 : 1)
      i_sehc_master.sel(1'h0);
      repeat (4) @(posedge clk);
      `CHK(byte_count, 8'h00)
      i_sehc_master.xfer(b, -1, 1'h0);
      repeat (8) @(posedge clk);
      `CHK(rx_byte, b)
    end else begin
      `CHK(nbits - k0, exp_bits(1))
      `CHK(rx_byte, b)
      `CHK(byte_count, 8'h01)
      `CHK(npause > 0, h >= 0)
      `CHK(sdo_o, exp_sdo)
      `CHK(sdo_oe, exp_oe)
    end
    `CHK(paused, 1'h0)
    i_sehc_master.sel(1'h1);
  endtask : frame
  // Main sequence.
  initial begin
    repeat (5) @(posedge clk);
    srst <= 1'h0;
    repeat (40) @(posedge clk);
    `CHK(if_ready, 1'h1)
    i_sehc_master.hold(10);
    `CHK(npause, 0)
    for (int i = 0; i < 9; i++) begin
      frame(i - 1, 1'h0, 1'($random(seed)));
      $display("test byte %0d done", i);
    end
    frame(3, 1'h1, 1'h0);
    frame(6, 1'h1, 1'h1);
    $display("test abort done");
    print_verdict();
  end
endmodule : sehc_top_tb
bind sehc_top sehc_checker i_sehc_checker (.clk(clk), .srst(srst), .sclk(sclk), .sel_n(sel_n),
  .pause_n(pause_n), .sdo_oe(sdo_oe), .bit_strobe(bit_strobe), .byte_strobe(byte_strobe), .rx_byte(rx_byte),
  .byte_count(byte_count), .paused(paused), .if_ready(if_ready), .abort_pulse(abort_pulse));
`default_nettype wire
